// *** bench/fcw_flash_model.sv ***
// Behavioural model of the byte-wide flash device seen by the host
`timescale 1ns/10ps
module fcw_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
  // Device pins
  input wire logic [19:0] addr,
  input wire logic [7:0] host_dq,
  input wire logic host_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_powerdown_n,
  output logic [7:0] dq_bus,
  output logic ready_busy_n,
  // Environment
  input wire logic program_supply_lockout,
  input wire logic supply_write_lockout,
  input wire logic [15:0] lock_bits,
  input wire logic [15:0] busy_ns
);
  logic [7:0] mem [logic [19:0]];
  logic [7:0] stat = 8'h80;
  logic [1:0] mode = 2'd0;
  logic [7:0] pend = 8'h00;
  logic [7:0] q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic susp = 1'b0;
  logic drive;

  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // ==========================================================
  // Read path
  initial ready_busy_n = 1'b1;
  assign drive = !ce_n && !oe_n && reset_powerdown_n;
  // A released bus shows the inverse of the last value, never a stale copy
  assign dq_bus = drive ? q : host_oe ? host_dq : ~last_q;
  always @(drive or addr or mode or stat) begin
    q = (mode == 2'd1) ? stat : (mode == 2'd2) ? ID_CODE : rd(addr);
    if (drive) last_q = q;
  end

  // ==========================================================
  // Write state machine
  task automatic alter(input logic er, input logic [19:0] a, input logic [7:0] d);
    mode = 2'd1;
    stat = 8'h00;
    ready_busy_n = 1'b0;
    for (int t = 0; t < busy_ns && reset_powerdown_n; t += 10) begin
      #10;
      // Suspended: ready shows high and the operation makes no progress
      while (susp && reset_powerdown_n) begin
        ready_busy_n = 1'b1;
        #10;
      end
      ready_busy_n = 1'b0;
    end
    ready_busy_n = 1'b1;
    if (!reset_powerdown_n) return;
    if (program_supply_lockout) stat = er ? 8'hA8 : 8'h98;
    else if (lock_bits[a[19:16]]) stat = er ? 8'hA2 : 8'h92;
    else begin
      stat = 8'h80;
      for (int i = 0; i < 65536 && er; i++) begin
        if (mem.exists({a[19:16], 16'(i)})) mem.delete({a[19:16], 16'(i)});
      end
      if (!er) mem[a] = rd(a) & d;
    end
  endtask

  always @(posedge we_n) begin
    if (!ce_n && reset_powerdown_n && !supply_write_lockout) begin
      if (!ready_busy_n || susp) begin
        // Busy or suspended: only suspend and resume are heard, and read array and read status once suspended
        case (host_dq)
          8'hB0: susp = 1'b1;
          8'hD0: susp = 1'b0;
          8'hFF: if (susp) mode = 2'd0;
          8'h70: if (susp) mode = 2'd1;
          default: ;
        endcase
      end else if (pend == 8'h40) begin
        pend = 8'h00;
        // Runs apart so that suspend commands are heard while busy
        fork
          alter(1'b0, addr, host_dq);
        join_none
      end else if (pend == 8'h20) begin
        pend = 8'h00;
        if (host_dq == 8'hD0) begin
          fork
            alter(1'b1, addr, 8'hFF);
          join_none
        end else begin
          stat = 8'hB0;
          mode = 2'd1;
        end
      end else begin
        case (host_dq)
          8'hFF: mode = 2'd0;
          8'h70: mode = 2'd1;
          8'h90: mode = 2'd2;
          8'h40, 8'h20: begin
            pend = host_dq;
            mode = 2'd1;
          end
          default: ;
        endcase
      end
    end
  end

  always @(negedge reset_powerdown_n) begin
    stat = 8'h80;
    mode = 2'd0;
    pend = 8'h00;
    susp = 1'b0;
  end
endmodule // fcw_flash_model

// *** bench/tb_fcw_host.sv ***
// Self-checking bench for the APB flash host against the device model
`timescale 1ns/10ps
`include "fcw_regs.svh"
module tb_fcw_host;
  localparam logic [31:0] W_ER = 32'hFF70_D020;
  logic mclk = 1'b0;
  logic reset, psel, penable, pwrite, pready, pslverr, re, seen, vpl, vlk;
  logic f_oe, f_ce, f_oen, f_we, f_pdn, rbn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [19:0] f_a, a, a0, a1;
  logic [7:0] f_do, f_dq, d, e;
  logic [15:0] lk, bn;
  logic [7:0] em [logic [19:0]];
  int seed, error_cnt, n_tests;

  always #20 mclk = ~mclk;
  always @(negedge rbn) seen = 1'b1;

  fcw_host u_fcw_host (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(f_a), .flash_dq_out(f_do), .flash_dq_oe(f_oe),
    .flash_dq_in(f_dq), .flash_ce_n(f_ce), .flash_oe_n(f_oen), .flash_we_n(f_we),
    .reset_powerdown_n(f_pdn), .ready_busy_n(rbn));
  fcw_flash_model u_fcw_flash_model (.addr(f_a), .host_dq(f_do), .host_oe(f_oe),
    .ce_n(f_ce), .oe_n(f_oen), .we_n(f_we), .reset_powerdown_n(f_pdn), .dq_bus(f_dq),
    .ready_busy_n(rbn), .program_supply_lockout(vpl), .supply_write_lockout(vlk),
    .lock_bits(lk), .busy_ns(bn));

  // ==========================================================
  // Expectations and checks
  function automatic logic [7:0] erd(input logic [19:0] x);
    return em.exists(x) ? em[x] : 8'hFF;
  endfunction

  function automatic logic [7:0] est(input logic er, input logic [19:0] x);
    if (vpl) return er ? 8'hA8 : 8'h98;
    if (lk[x[19:16]]) return er ? 8'hA2 : 8'h92;
    return 8'h80;
  endfunction

  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", s, x, g);
      error_cnt++;
    end
  endtask

  task end_sim;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic idle;
    for (int k = 0; k < 200; k++) begin
      apb(1'b0, `FCW_ADDR_STATUS, 32'h0);
      if (rq[0] === 1'b0) return;
    end
    $display("[ERR] idle timeout expected 0 seen 1");
    error_cnt++;
  endtask

  // Byte data for a single write travels in the first command byte
  task automatic run(input logic [1:0] op, input logic [19:0] x, input logic [31:0] cw);
    seen = 1'b0;
    apb(1'b1, `FCW_ADDR_ADDR, {12'h000, x});
    apb(1'b1, `FCW_ADDR_WDATA, {24'h00_0000, cw[7:0]});
    apb(1'b1, `FCW_ADDR_CODES, cw);
    apb(1'b1, `FCW_ADDR_CTRL, {27'h000_0000, 1'b1, 2'b00, op});
    for (int k = 0; k < 500; k++) begin
      apb(1'b0, `FCW_ADDR_STATUS, 32'h0);
      if (rq[1] === 1'b1) return;
    end
    $display("[ERR] done timeout expected 1 seen 0");
    error_cnt++;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    end_sim;
  end

  // ==========================================================
  // Scenarios
  initial begin
    seed = 19470;
    {reset, psel, penable, pwrite, vpl, vlk} = 6'b100000;
    paddr = 12'h000;
    pwdata = 32'h0;
    lk = 16'h8000;
    bn = 16'h0200;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    idle;
    chk("pd pin high", 8'h01, 8'(f_pdn));
    chk("ready pin", 8'h01, 8'(rbn));
    for (int i = 0; i < 6; i++) begin
      a = 20'($random(seed));
      a[19:16] = (i == 5) ? 4'hF : 4'(i);
      d = 8'($random(seed));
      bn = 16'h0100 | (16'($random(seed)) & 16'h0FFF);
      e = est(1'b0, a);
      if (e == 8'h80) em[a] = erd(a) & d;
      run(2'd2, a, {16'hFF70, d, 8'h40});
      chk("write status", e, rq[15:8]);
      chk("busy seen", 8'h01, 8'(seen));
      chk("ready after", 8'h01, 8'(rq[2]));
      run(2'd0, a, 32'h0);
      chk("read back", erd(a), rq[15:8]);
      if (i == 0) a0 = a;
      if (i == 1) a1 = a;
    end
    run(2'd2, a0, W_ER);
    chk("erase status", 8'h80, rq[15:8]);
    em[a0] = 8'hFF;
    run(2'd0, a0, 32'h0);
    chk("erased", 8'hFF, rq[15:8]);
    run(2'd0, a1, 32'h0);
    chk("other block", erd(a1), rq[15:8]);
    run(2'd2, 20'hF_0000, W_ER);
    chk("locked erase", est(1'b1, 20'hF_0000), rq[15:8]);
    vpl = 1'b1;
    run(2'd2, a1, 32'hFF70_0040);
    chk("lockout status", est(1'b0, a1), rq[15:8]);
    run(2'd0, a1, 32'h0);
    chk("lockout data", erd(a1), rq[15:8]);
    run(2'd3, a1, 32'hFF70_0000);
    chk("status read", 8'h98, rq[15:8]);
    run(2'd1, a1, 32'h90);
    run(2'd0, a1, 32'h0);
    chk("identifier", 8'h5A, rq[15:8]);
    run(2'd1, a1, 32'hFF);
    vpl = 1'b0;
    run(2'd1, a1, 32'hD0);
    run(2'd0, a1, 32'h0);
    chk("stray confirm", erd(a1), rq[15:8]);
    run(2'd1, a1, 32'h20);
    run(2'd1, a1, 32'hFF);
    run(2'd0, a1, 32'h0);
    chk("bad sequence", 8'hB0, rq[15:8]);
    run(2'd1, a1, 32'hFF);
    // Byte write started by two single writes, then suspended mid-way
    bn = 16'hFFFF;
    run(2'd1, a1, 32'h40);
    run(2'd1, a1, 32'h11);
    run(2'd1, a1, 32'hB0);
    run(2'd1, a1, 32'hFF);
    run(2'd0, a0, 32'h0);
    chk("suspended read", erd(a0), rq[15:8]);
    chk("suspended ready", 8'h01, 8'(rq[2]));
    run(2'd1, a1, 32'h40);
    run(2'd1, a1, 32'hD0);
    @(posedge rbn);
    @(posedge mclk);
    em[a1] = erd(a1) & 8'h11;
    run(2'd3, a1, 32'hFF70_0000);
    chk("resumed status", 8'h80, rq[15:8]);
    run(2'd0, a1, 32'h0);
    chk("resumed write", erd(a1), rq[15:8]);
    vlk = 1'b1;
    run(2'd1, a1, 32'h70);
    run(2'd0, a1, 32'h0);
    chk("supply lockout", erd(a1), rq[15:8]);
    vlk = 1'b0;
    run(2'd1, a1, 32'h70);
    apb(1'b1, `FCW_ADDR_CTRL, 32'h0000_0100);
    apb(1'b0, `FCW_ADDR_STATUS, 32'h0);
    chk("pd status", 8'h01, 8'(rq[3]));
    chk("pd pin", 8'h00, 8'(f_pdn));
    chk("pd ready", 8'h01, 8'(rbn));
    apb(1'b1, `FCW_ADDR_CTRL, 32'h0);
    idle;
    run(2'd0, a1, 32'h0);
    chk("wake array", erd(a1), rq[15:8]);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 8'h01, 8'(re));
    chk("unmapped data", 8'h00, rq[7:0]);
    end_sim;
  end
endmodule // tb_fcw_host

// *** verilog/fcw_host.sv ***
// Host controller driving an asynchronous byte-wide flash over its pins, APB-controlled
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "fcw_regs.svh"

module fcw_host #(
  parameter int ACC_CYC = `FCW_ACC_CYC,
  parameter int WP_CYC = `FCW_WP_CYC,
  parameter int PD_CYC = `FCW_PD_CYC,
  parameter int WAKE_CYC = `FCW_WAKE_CYC,
  parameter int SETTLE_CYC = `FCW_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [19:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  input wire logic ready_busy_n
);
  import fcw_pkg::*;

  localparam fcw_host_state_type RESET_STATE = '{
    st: ST_PD, op: OP_READ, step: `FCW_STEP_END, cnt: 8'(PD_CYC), pd_req: 1'b0,
    addr: `FCW_ADDR_RESET, wdata: `FCW_WDATA_RESET, codes: `FCW_CODES_RESET,
    done: 1'b0, rdata: 8'h00, f_addr: 20'h0_0000, f_dq: 8'h00, f_dq_oe: 1'b0,
    f_ce_n: 1'b1, f_oe_n: 1'b1, f_we_n: 1'b1, f_pwrdn_n: 1'b0,
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000
  };

  fcw_host_state_type q;
  fcw_host_state_type next_q;
  logic rb_n;
  logic [7:0] dq_sync;

  // ==========================================================
  // Pin input synchronisers
  fcw_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_rb (
    .mclk(mclk),
    .reset(reset),
    .din(ready_busy_n),
    .dout(rb_n)
  );

  fcw_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_dq (
    .mclk(mclk),
    .reset(reset),
    .din(flash_dq_in),
    .dout(dq_sync)
  );

  // ==========================================================
  // Sequence helpers
  function automatic logic [2:0] step_after(fcw_op_type op, logic [2:0] stp);
    if (op == OP_READ || op == OP_WRITE || stp == `FCW_STEP_ARRAYCMD) begin
      step_after = `FCW_STEP_END;
    end else begin
      step_after = 3'(stp + 3'h1);
    end
  endfunction

  // Starts the bus cycle or wait that belongs to a step
  function automatic fcw_host_state_type launch(fcw_host_state_type s, logic [2:0] stp);
    fcw_host_state_type r;
    r = s;
    r.step = stp;
    r.f_addr = s.addr;
    if (stp == `FCW_STEP_END) begin
      r.st = ST_IDLE;
      r.done = 1'b1;
    end else if (stp == `FCW_STEP_WAIT) begin
      // Give the device time to pull ready/busy low before polling it
      r.st = ST_SETTLE;
      r.cnt = 8'(SETTLE_CYC);
    end else if (stp == `FCW_STEP_STATREAD || (stp == `FCW_STEP_FIRST && s.op == OP_READ)) begin
      r.st = ST_RWAIT;
      r.f_dq_oe = 1'b0;
      r.f_ce_n = 1'b0;
      r.f_oe_n = 1'b0;
      r.cnt = 8'(ACC_CYC + `FCW_SYNC_LAT);
    end else begin
      r.st = ST_WSETUP;
      r.f_ce_n = 1'b0;
      r.f_oe_n = 1'b1;
      r.f_dq_oe = 1'b1;
      case (stp)
        `FCW_STEP_FIRST: begin
          r.f_dq = (s.op == OP_WRITE) ? s.wdata : s.codes[`FCW_CODES_FIRST_LSB +: 8];
        end
        `FCW_STEP_SECOND: begin
          r.f_dq = s.codes[`FCW_CODES_SECOND_LSB +: 8];
        end
        `FCW_STEP_STATCMD: begin
          r.f_dq = s.codes[`FCW_CODES_STATUS_LSB +: 8];
        end
        default: begin
          r.f_dq = s.codes[`FCW_CODES_ARRAY_LSB +: 8];
        end
      endcase
    end
    launch = r;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_q = q;
    // APB: one wait state, the access completes when pready is seen high
    next_q.pready = psel && penable && !q.pready;
    next_q.pslverr = 1'b0;
    next_q.prdata = 32'h0000_0000;
    if (psel && penable && !q.pready) begin
      case (paddr)
        `FCW_ADDR_CTRL: begin
          next_q.prdata[`FCW_CTRL_OP_LSB +: 2] = q.op;
          next_q.prdata[`FCW_CTRL_PD_BIT] = q.pd_req;
        end
        `FCW_ADDR_ADDR: next_q.prdata[19:0] = q.addr;
        `FCW_ADDR_WDATA: next_q.prdata[7:0] = q.wdata;
        `FCW_ADDR_CODES: next_q.prdata = q.codes;
        `FCW_ADDR_STATUS: begin
          next_q.prdata[`FCW_STAT_BUSY_BIT] = (q.st != ST_IDLE);
          next_q.prdata[`FCW_STAT_DONE_BIT] = q.done;
          next_q.prdata[`FCW_STAT_READY_BIT] = rb_n;
          next_q.prdata[`FCW_STAT_PD_BIT] = !q.f_pwrdn_n;
          next_q.prdata[`FCW_STAT_RDATA_LSB +: 8] = q.rdata;
        end
        default: next_q.pslverr = 1'b1;
      endcase
    end

    // Sequencer
    case (q.st)
      ST_IDLE: begin
        next_q.f_ce_n = 1'b1;
        next_q.f_oe_n = 1'b1;
        next_q.f_we_n = 1'b1;
        next_q.f_dq_oe = 1'b0;
      end
      ST_WSETUP: begin
        // Chip enable comes back low for a follow-on command write
        next_q.f_ce_n = 1'b0;
        next_q.f_we_n = 1'b0;
        next_q.cnt = 8'(WP_CYC - 1);
        next_q.st = ST_WPULSE;
      end
      ST_WPULSE: begin
        if (q.cnt == 8'h00) begin
          next_q.f_we_n = 1'b1;
          next_q.st = ST_WHOLD;
        end else begin
          next_q.cnt = 8'(q.cnt - 8'h01);
        end
      end
      ST_WHOLD: begin
        // Address and data stay one cycle past the write-enable rise
        next_q = launch(next_q, step_after(q.op, q.step));
        if (next_q.st != ST_WSETUP) begin
          next_q.f_ce_n = (next_q.st != ST_RWAIT);
          next_q.f_dq_oe = 1'b0;
        end else begin
          next_q.f_ce_n = 1'b1;
          next_q.st = ST_WSETUP;
        end
      end
      ST_RWAIT: begin
        if (q.cnt == 8'h00) begin
          next_q.rdata = dq_sync;
          next_q.f_ce_n = 1'b1;
          next_q.f_oe_n = 1'b1;
          next_q = launch(next_q, step_after(q.op, q.step));
        end else begin
          next_q.cnt = 8'(q.cnt - 8'h01);
        end
      end
      ST_SETTLE: begin
        if (q.cnt == 8'h00) begin
          next_q.st = ST_POLL;
        end else begin
          next_q.cnt = 8'(q.cnt - 8'h01);
        end
      end
      ST_POLL: begin
        // No limit: the device alone decides how long the operation runs
        if (rb_n) begin
          next_q = launch(next_q, `FCW_STEP_STATCMD);
        end
      end
      ST_PD: begin
        if (q.cnt != 8'h00) begin
          next_q.cnt = 8'(q.cnt - 8'h01);
        end else if (!q.pd_req) begin
          next_q.f_pwrdn_n = 1'b1;
          next_q.cnt = 8'(WAKE_CYC);
          next_q.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Device returns to read array by itself, so no command is sent
        if (q.cnt == 8'h00) begin
          next_q.st = ST_IDLE;
        end else begin
          next_q.cnt = 8'(q.cnt - 8'h01);
        end
      end
      default: next_q.st = ST_IDLE;
    endcase

    // APB writes take effect at the completing edge
    if (psel && penable && q.pready && pwrite) begin
      case (paddr)
        `FCW_ADDR_CTRL: begin
          next_q.pd_req = pwdata[`FCW_CTRL_PD_BIT];
          if (pwdata[`FCW_CTRL_GO_BIT] && q.st == ST_IDLE && !pwdata[`FCW_CTRL_PD_BIT]) begin
            next_q.op = fcw_op_type'(pwdata[`FCW_CTRL_OP_LSB +: 2]);
            next_q.done = 1'b0;
            next_q = launch(next_q, (next_q.op == OP_STATUS) ?
                            `FCW_STEP_STATCMD : `FCW_STEP_FIRST);
          end
        end
        `FCW_ADDR_ADDR: next_q.addr = pwdata[19:0];
        `FCW_ADDR_WDATA: next_q.wdata = pwdata[7:0];
        `FCW_ADDR_CODES: next_q.codes = pwdata;
        default: next_q.codes = next_q.codes;
      endcase
    end

    // Powerdown aborts any cycle; all writes stop while the pin is low
    if (next_q.pd_req && q.st != ST_PD) begin
      next_q.st = ST_PD;
      next_q.cnt = 8'(PD_CYC - 1);
      next_q.f_pwrdn_n = 1'b0;
      next_q.f_ce_n = 1'b1;
      next_q.f_oe_n = 1'b1;
      next_q.f_we_n = 1'b1;
      next_q.f_dq_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign flash_addr = q.f_addr;
  assign flash_dq_out = q.f_dq;
  assign flash_dq_oe = q.f_dq_oe;
  assign flash_ce_n = q.f_ce_n;
  assign flash_oe_n = q.f_oe_n;
  assign flash_we_n = q.f_we_n;
  assign reset_powerdown_n = q.f_pwrdn_n;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_no_contention;
    flash_dq_oe |-> flash_oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives dq with oe low");

  property p_we_hold;
    $rose(flash_we_n) && !flash_ce_n |-> $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("address or data moved after we rise");

  property p_no_write_pd;
    !reset_powerdown_n |-> flash_we_n && flash_ce_n;
  endproperty
  a_no_write_pd: assert property (p_no_write_pd) else $error("write during powerdown");

  property p_pd_min;
    $fell(reset_powerdown_n) |=> !reset_powerdown_n [*2];
  endproperty
  a_pd_min: assert property (p_pd_min) else $error("powerdown pulse too short");

  property p_poll_busy;
    q.st == ST_POLL && !rb_n && !next_q.pd_req |=> q.st == ST_POLL;
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("left poll while busy");

  property p_status_after;
    q.st == ST_POLL && rb_n && !next_q.pd_req |=> q.step == `FCW_STEP_STATCMD && q.st == ST_WSETUP;
  endproperty
  a_status_after: assert property (p_status_after) else $error("no status check after op");

  property p_array_after;
    q.st == ST_RWAIT && q.step == `FCW_STEP_STATREAD && q.cnt == 8'h00 && !next_q.pd_req
      |=> q.step == `FCW_STEP_ARRAYCMD && flash_dq_out == q.codes[31:24];
  endproperty
  a_array_after: assert property (p_array_after) else $error("no read-array after status");

  property p_two_step;
    q.st == ST_WHOLD && q.op == OP_TWO_STEP && q.step == `FCW_STEP_FIRST && !next_q.pd_req
      |=> q.step == `FCW_STEP_SECOND && flash_dq_out == q.codes[15:8];
  endproperty
  a_two_step: assert property (p_two_step) else $error("second command write missing");

  property p_read_gated;
    !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe;
  endproperty
  a_read_gated: assert property (p_read_gated) else $error("bad read cycle pins");

  property p_wake_idle;
    $rose(reset_powerdown_n) |-> q.st == ST_WAKE;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("no wake interval");
endmodule // fcw_host

// *** verilog/fcw_pkg.sv ***
// Types shared by the flash host controller
package fcw_pkg;

  // ==========================================================
  // Sequencer states and operations
  typedef enum logic [3:0] {
    ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_RWAIT, ST_SETTLE, ST_POLL, ST_PD, ST_WAKE
  } fcw_state_type;

  typedef enum logic [1:0] {
    OP_READ, OP_WRITE, OP_TWO_STEP, OP_STATUS
  } fcw_op_type;

  // ==========================================================
  // Whole state of the host controller
  typedef struct packed {
    fcw_state_type st;
    fcw_op_type op;
    logic [2:0] step;
    logic [7:0] cnt;
    logic pd_req;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [31:0] codes;
    logic done;
    logic [7:0] rdata;
    logic [19:0] f_addr;
    logic [7:0] f_dq;
    logic f_dq_oe;
    logic f_ce_n;
    logic f_oe_n;
    logic f_we_n;
    logic f_pwrdn_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fcw_host_state_type;

endpackage

// *** verilog/fcw_regs.svh ***
// Register map, field positions, reset values and timing counts of the flash host
`ifndef FCW_REGS_SVH
`define FCW_REGS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define FCW_ADDR_CTRL 12'h000
`define FCW_ADDR_ADDR 12'h004
`define FCW_ADDR_WDATA 12'h008
`define FCW_ADDR_CODES 12'h00C
`define FCW_ADDR_STATUS 12'h010

// ==========================================================
// Field positions
`define FCW_CTRL_OP_LSB 0
`define FCW_CTRL_GO_BIT 4
`define FCW_CTRL_PD_BIT 8
`define FCW_CODES_FIRST_LSB 0
`define FCW_CODES_SECOND_LSB 8
`define FCW_CODES_STATUS_LSB 16
`define FCW_CODES_ARRAY_LSB 24
`define FCW_STAT_BUSY_BIT 0
`define FCW_STAT_DONE_BIT 1
`define FCW_STAT_READY_BIT 2
`define FCW_STAT_PD_BIT 3
`define FCW_STAT_RDATA_LSB 8

// ==========================================================
// Reset values
`define FCW_CODES_RESET 32'h0000_0000
`define FCW_ADDR_RESET 20'h0_0000
`define FCW_WDATA_RESET 8'h00

// ==========================================================
// Sequence steps
`define FCW_STEP_FIRST 3'h0
`define FCW_STEP_SECOND 3'h1
`define FCW_STEP_WAIT 3'h2
`define FCW_STEP_STATCMD 3'h3
`define FCW_STEP_STATREAD 3'h4
`define FCW_STEP_ARRAYCMD 3'h5
`define FCW_STEP_END 3'h6

// ==========================================================
// Timing: figures in ns, counts in mclk cycles
`define FCW_CLK_NS 40
`define FCW_T_ACC_NS 85
`define FCW_T_WP_NS 50
`define FCW_T_PD_NS 100
`define FCW_T_WAKE_NS 1000
`define FCW_T_SETTLE_NS 200
`define FCW_SYNC_LAT 3
`define FCW_ACC_CYC ((`FCW_T_ACC_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WP_CYC ((`FCW_T_WP_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_PD_CYC ((`FCW_T_PD_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WAKE_CYC ((`FCW_T_WAKE_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_SETTLE_CYC ((`FCW_T_SETTLE_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)

`endif

// *** verilog/fcw_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module fcw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import fcw_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } fcw_sync_type;

  fcw_sync_type q;
  fcw_sync_type next_q;

  // A change is taken only once stages two and three agree
  always_comb begin
    next_q = q;
    next_q.s1 = din;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.val = q.s3;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, val: INIT};
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.val;
endmodule // fcw_sync
